// ===== rtl/gauge_command_register_bank.sv
// Host-visible command, pin and result registers of the capacity monitor
`timescale 1ns/1ps
module gauge_command_register_bank
   import gauge_cmd_pkg::*;
#(
   parameter int unsigned REFRESH_CYCLES = REFRESH_CYCLES_DEF  // Two-second refresh
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Byte register access from the serial link decoder
   input  wire logic [6:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Values from the measurement core
   input  wire logic [15:0] at_rate_capacity,
   input  wire logic [15:0] temp_meas,
   input  wire logic [15:0] volt_meas,
   input  wire logic        full_charge,
   input  wire logic [7:0]  pack_configuration,
   input  wire logic [15:0] init_learned_cap,
   // General-purpose pin, open drain
   input  wire logic        gp_pin_i,
   output logic             gp_pin_o,
   output logic             gp_pin_oe,
   // State driven back into the core
   output logic      [15:0] nominal_available_capacity,
   output logic      [15:0] last_measured_discharge,
   output logic             capacity_inaccurate_flag,
   output logic             ship_mode,
   output logic             full_reinit,
   output logic             partial_reinit
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic {CMD_IDLE, CMD_EXEC} cmd_state_t;

   localparam int unsigned RCNT_W = $clog2(REFRESH_CYCLES + 1);

   cmd_state_t        state_r;         // Command sequencer
   cmd_sel_t          sel_r;           // Command chosen at key write
   cmd_sel_t          sel_nxt;         // Priority pick of pending bits
   logic [7:0]        trigger_r;       // Trigger register
   logic [7:0]        cmd_pin_r;       // Command and pin control bits
   logic              dir_load_r;      // Strap copy still pending
   logic [15:0]       at_rate_r;       // Host at-rate value
   logic [15:0]       tte_r;           // Time-to-empty, minutes
   logic [15:0]       temp_r;          // Reported temperature
   logic [15:0]       volt_r;          // Reported voltage
   logic [15:0]       avail_cap_r;     // Nominal available capacity
   logic [15:0]       learned_cap_r;   // Last measured discharge
   logic              cap_inacc_r;     // Capacity inaccurate
   logic              ship_r;          // Ship mode level
   logic              full_pulse_r;    // Full reinit strobe
   logic              part_pulse_r;    // Partial reinit strobe
   logic              pin_oe_r;        // Pull-low enable
   logic              pin_o_r;         // Open-drain data, always low
   logic [7:0]        rdata_r;         // Read data
   logic [RCNT_W-1:0] refresh_cnt_r;   // Refresh timer
   logic              pin_sync;        // Synchronised pin level
   logic              key_write;       // Accepted trigger write
   logic              reinit;          // Any reinit in this cycle
   logic              div_busy;        // Divider running
   logic              div_done;        // Divider result ready
   logic [21:0]       div_quot;        // Divider quotient
   logic [21:0]       tte_numer;       // Sixty times capacity
   logic [7:0]        cmd_pin_view;    // Command register as read

   // ----------------------------------------------------------------
   // Pin synchroniser and divider
   // ----------------------------------------------------------------
   level_sync #(
      .WIDTH    (1)
   ) u_pin_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (gp_pin_i),
      .sync_out (pin_sync)
   );

   // Numerator widened before the product so nothing is lost
   assign tte_numer = 22'({6'h00, at_rate_capacity} * MIN_PER_HOUR);

   tte_divider #(
      .NUM_W (22),
      .DEN_W (16)
   ) u_tte_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (!div_busy && !div_done),
      .numer   (tte_numer),
      .denom   (at_rate_r),
      .busy    (div_busy),
      .done    (div_done),
      .quot    (div_quot)
   );

   // ----------------------------------------------------------------
   // Command selection
   // ----------------------------------------------------------------

   // Key write: trigger address, exact key, sequencer free
   assign key_write = reg_wr && (reg_addr == ADDR_TRIGGER)
                      && (reg_wdata == TRIGGER_KEY) && (state_r == CMD_IDLE);

   // Highest bit position wins
   always_comb
   begin
      if (cmd_pin_r[BIT_LOAD])
      begin
         sel_nxt = SEL_LOAD;
      end
      else if (cmd_pin_r[BIT_MARK])
      begin
         sel_nxt = SEL_MARK;
      end
      else if (cmd_pin_r[BIT_PARTIAL])
      begin
         sel_nxt = SEL_PARTIAL;
      end
      else if (cmd_pin_r[BIT_FULL])
      begin
         sel_nxt = SEL_FULL;
      end
      else if (cmd_pin_r[BIT_SHIP])
      begin
         sel_nxt = SEL_SHIP;
      end
      else
      begin
         sel_nxt = SEL_NONE;
      end
   end

   // Both reset commands reinitialise the volatile results
   assign reinit = (state_r == CMD_EXEC)
                   && ((sel_r == SEL_FULL) || (sel_r == SEL_PARTIAL));

   // ----------------------------------------------------------------
   // Sequencer: idle, then one execute cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_r <= CMD_IDLE;
         sel_r   <= SEL_NONE;
      end
      else
      begin
         unique case (state_r)
            CMD_IDLE:
            begin
               // Pending bits sit here until the key arrives
               if (key_write)
               begin
                  state_r <= CMD_EXEC;
                  sel_r   <= sel_nxt;
               end
            end
            CMD_EXEC:
            begin
               // Action takes exactly one cycle
               state_r <= CMD_IDLE;
               sel_r   <= SEL_NONE;
            end
         endcase
      end
   end

   // Trigger register holds the key until the action completes
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         trigger_r <= BYTE_ZERO;
      end
      else if (key_write)
      begin
         trigger_r <= TRIGGER_KEY;
      end
      else if (state_r == CMD_EXEC)
      begin
         trigger_r <= BYTE_ZERO;
      end
   end

   // ----------------------------------------------------------------
   // Command and pin control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         // Direction input until strap copied; level released; power-on set
         cmd_pin_r  <= CMD_PIN_RESET;
         dir_load_r <= 1'b1;
      end
      else
      begin
         // Strap bit caught on the first edge after release
         if (dir_load_r)
         begin
            cmd_pin_r[BIT_DIR] <= pack_configuration[BIT_DIR];
            dir_load_r         <= 1'b0;
         end
         // Completion clears every command bit
         if (state_r == CMD_EXEC)
         begin
            cmd_pin_r <= cmd_pin_r & ~CMD_BITS_MASK;
         end
         // Full charge clears the power-on status
         if (full_charge)
         begin
            cmd_pin_r[BIT_POWER_ON] <= 1'b0;
         end
         // Host write lands last, so a new command is not lost
         if (reg_wr && (reg_addr == ADDR_CMD_PIN))
         begin
            cmd_pin_r <= reg_wdata;
         end
      end
   end

   // Level bit reads the pin while the pin is an input
   always_comb
   begin
      cmd_pin_view = cmd_pin_r;
      if (cmd_pin_r[BIT_DIR])
      begin
         cmd_pin_view[BIT_LEVEL] = pin_sync;
      end
   end

   // Open-drain drive: pull low only as output with level zero
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_oe_r <= 1'b0;
         pin_o_r  <= 1'b0;
      end
      else
      begin
         pin_oe_r <= !cmd_pin_r[BIT_DIR] && !cmd_pin_r[BIT_LEVEL];
         pin_o_r  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // At-rate value and time-to-empty
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         at_rate_r <= WORD_ZERO;
      end
      else if (reinit)
      begin
         at_rate_r <= WORD_ZERO;
      end
      else if (reg_wr && (reg_addr == ADDR_RATE_LO))
      begin
         at_rate_r[7:0] <= reg_wdata;
      end
      else if (reg_wr && (reg_addr == ADDR_RATE_HI))
      begin
         at_rate_r[15:8] <= reg_wdata;
      end
   end

   // Result written by the divider and cleared by reinit, never by the host
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tte_r <= WORD_ZERO;
      end
      else if (reinit)
      begin
         tte_r <= WORD_ZERO;
      end
      else if (div_done)
      begin
         // Zero rate or overflow saturates
         if ((at_rate_r == WORD_ZERO) || (div_quot[21:16] != 6'h00))
         begin
            tte_r <= TTE_SATURATED;
         end
         else
         begin
            tte_r <= div_quot[15:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Temperature and voltage refresh
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         refresh_cnt_r <= '0;
         temp_r        <= WORD_ZERO;
         volt_r        <= WORD_ZERO;
      end
      else if (reinit)
      begin
         refresh_cnt_r <= '0;
         temp_r        <= WORD_ZERO;
         volt_r        <= WORD_ZERO;
      end
      else if (refresh_cnt_r == RCNT_W'(REFRESH_CYCLES - 1))
      begin
         refresh_cnt_r <= '0;
         temp_r        <= temp_meas;
         volt_r        <= (volt_meas > VOLT_MAX_MV) ? VOLT_MAX_MV : volt_meas;
      end
      else
      begin
         refresh_cnt_r <= refresh_cnt_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Capacity registers and command effects
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         avail_cap_r   <= AVAIL_INIT;
         learned_cap_r <= WORD_ZERO;
         cap_inacc_r   <= 1'b1;
      end
      else if (state_r == CMD_EXEC)
      begin
         unique case (sel_r)
            SEL_LOAD:
            begin
               avail_cap_r <= at_rate_r;
            end
            SEL_MARK:
            begin
               learned_cap_r <= avail_cap_r;
            end
            SEL_FULL:
            begin
               avail_cap_r   <= AVAIL_INIT;
               learned_cap_r <= init_learned_cap;
               cap_inacc_r   <= 1'b1;
            end
            SEL_NONE, SEL_PARTIAL, SEL_SHIP:
            begin
               // Partial reset keeps capacities and the flag
               avail_cap_r <= avail_cap_r;
            end
         endcase
      end
   end

   // Reinit strobes and ship level toward the core
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         full_pulse_r <= 1'b0;
         part_pulse_r <= 1'b0;
         ship_r       <= 1'b0;
      end
      else
      begin
         full_pulse_r <= (state_r == CMD_EXEC) && (sel_r == SEL_FULL);
         part_pulse_r <= (state_r == CMD_EXEC) && (sel_r == SEL_PARTIAL);
         // Enter on command; any later link access wakes
         if ((state_r == CMD_EXEC) && (sel_r == SEL_SHIP))
         begin
            ship_r <= 1'b1;
         end
         else if (reg_wr || reg_rd)
         begin
            ship_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data, one cycle after the read strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_r <= BYTE_ZERO;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_TRIGGER:  rdata_r <= trigger_r;
            ADDR_CMD_PIN:  rdata_r <= cmd_pin_view;
            ADDR_RATE_LO:  rdata_r <= at_rate_r[7:0];
            ADDR_RATE_HI:  rdata_r <= at_rate_r[15:8];
            ADDR_TTE_LO:   rdata_r <= tte_r[7:0];
            ADDR_TTE_HI:   rdata_r <= tte_r[15:8];
            ADDR_TEMP_LO:  rdata_r <= temp_r[7:0];
            ADDR_TEMP_HI:  rdata_r <= temp_r[15:8];
            ADDR_VOLT_LO:  rdata_r <= volt_r[7:0];
            ADDR_VOLT_HI:  rdata_r <= volt_r[15:8];
            ADDR_AVAIL_LO: rdata_r <= avail_cap_r[7:0];
            ADDR_AVAIL_HI: rdata_r <= avail_cap_r[15:8];
            ADDR_LEARN_LO: rdata_r <= learned_cap_r[7:0];
            ADDR_LEARN_HI: rdata_r <= learned_cap_r[15:8];
            default:       rdata_r <= BYTE_ZERO;  // Unmapped reads zero
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata                  = rdata_r;
   assign gp_pin_o                   = pin_o_r;
   assign gp_pin_oe                  = pin_oe_r;
   assign nominal_available_capacity = avail_cap_r;
   assign last_measured_discharge    = learned_cap_r;
   assign capacity_inaccurate_flag   = cap_inacc_r;
   assign ship_mode                  = ship_r;
   assign full_reinit                = full_pulse_r;
   assign partial_reinit             = part_pulse_r;

endmodule : gauge_command_register_bank

// ===== include/gauge_cmd_pkg.sv
// Shared constants for the gauge command and reporting register bank
package gauge_cmd_pkg;

   // ----------------------------------------------------------------
   // Register addresses (byte addresses on the serial link)
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_TRIGGER   = 7'h00;  // Command trigger
   localparam logic [6:0] ADDR_CMD_PIN   = 7'h01;  // Command and pin control
   localparam logic [6:0] ADDR_RATE_LO   = 7'h02;  // At-rate low byte
   localparam logic [6:0] ADDR_RATE_HI   = 7'h03;  // At-rate high byte
   localparam logic [6:0] ADDR_TTE_LO    = 7'h04;  // Time-to-empty low byte
   localparam logic [6:0] ADDR_TTE_HI    = 7'h05;  // Time-to-empty high byte
   localparam logic [6:0] ADDR_TEMP_LO   = 7'h06;  // Temperature low byte
   localparam logic [6:0] ADDR_TEMP_HI   = 7'h07;  // Temperature high byte
   localparam logic [6:0] ADDR_VOLT_LO   = 7'h08;  // Voltage low byte
   localparam logic [6:0] ADDR_VOLT_HI   = 7'h09;  // Voltage high byte
   localparam logic [6:0] ADDR_AVAIL_LO  = 7'h0c;  // Available capacity low
   localparam logic [6:0] ADDR_AVAIL_HI  = 7'h0d;  // Available capacity high
   localparam logic [6:0] ADDR_LEARN_LO  = 7'h12;  // Learned capacity low
   localparam logic [6:0] ADDR_LEARN_HI  = 7'h13;  // Learned capacity high

   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam logic [7:0]  TRIGGER_KEY    = 8'ha9;  // Only accepted trigger value
   localparam int unsigned BIT_DIR        = 7;      // Pin direction select
   localparam int unsigned BIT_LEVEL      = 6;      // Pin level
   localparam int unsigned BIT_LOAD       = 5;      // Load capacity command
   localparam int unsigned BIT_MARK       = 4;      // Mark full command
   localparam int unsigned BIT_PARTIAL    = 3;      // Partial reset command
   localparam int unsigned BIT_POWER_ON   = 2;      // Power-on status
   localparam int unsigned BIT_FULL       = 1;      // Full reset command
   localparam int unsigned BIT_SHIP       = 0;      // Ship command
   localparam logic [7:0]  CMD_BITS_MASK  = 8'h3b;  // All command bits
   localparam logic [7:0]  CMD_PIN_RESET  = 8'hc4;  // Input, released, power-on set
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;  // Cleared byte register
   localparam logic [15:0] VOLT_MAX_MV    = 16'h1388; // 5000 mV ceiling
   localparam logic [21:0] MIN_PER_HOUR   = 22'h00003c; // 60 minutes
   localparam logic [15:0] AVAIL_INIT     = 16'h0000; // Capacity after reset or full reinit
   localparam logic [15:0] WORD_ZERO      = 16'h0000; // Cleared result word
   localparam logic [15:0] TTE_SATURATED  = 16'hffff; // Zero rate or overflow

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint unsigned CLK_HZ           = 40_000_000;
   localparam longint unsigned REFRESH_PERIOD_S = 2;
   localparam int unsigned     REFRESH_CYCLES_DEF =
      int'(REFRESH_PERIOD_S * CLK_HZ);

   // Selected command, in priority order
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_LOAD,
      SEL_MARK,
      SEL_PARTIAL,
      SEL_FULL,
      SEL_SHIP
   } cmd_sel_t;

endpackage : gauge_cmd_pkg

// ===== rtl/level_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module level_sync #(
   parameter int unsigned WIDTH = 1  // Number of levels carried
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;  // First stage, read only by second stage
   logic [WIDTH-1:0] sync_r;  // Second stage

   // Two stages in series
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule : level_sync

// ===== rtl/tte_divider.sv
// Sequential restoring divider for the time-to-empty estimate
`timescale 1ns/1ps
module tte_divider #(
   parameter int unsigned NUM_W = 22,  // Dividend width
   parameter int unsigned DEN_W = 16   // Divisor width
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             start,
   input  wire logic [NUM_W-1:0] numer,
   input  wire logic [DEN_W-1:0] denom,
   output logic                  busy,
   output logic                  done,
   output logic      [NUM_W-1:0] quot
);

   localparam int unsigned CNT_W = $clog2(NUM_W + 1);
   localparam logic [CNT_W-1:0] STEPS = CNT_W'(NUM_W);

   logic [DEN_W:0]   rem_r;    // Partial remainder
   logic [NUM_W-1:0] quot_r;   // Shifts dividend out, quotient in
   logic [DEN_W-1:0] den_r;    // Latched divisor
   logic [CNT_W-1:0] cnt_r;    // Steps left
   logic             done_r;   // One-cycle completion
   logic [DEN_W:0]   rem_sh;   // Remainder with next dividend bit
   logic             fits;     // Divisor fits the remainder

   // One quotient bit per cycle
   always_comb
   begin
      rem_sh = {rem_r[DEN_W-1:0], quot_r[NUM_W-1]};
      fits   = (rem_sh >= {1'b0, den_r});
   end

   // Iteration control
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rem_r  <= '0;
         quot_r <= '0;
         den_r  <= '0;
         cnt_r  <= '0;
         done_r <= 1'b0;
      end
      else if (cnt_r == '0)
      begin
         done_r <= 1'b0;
         if (start)
         begin
            rem_r  <= '0;
            quot_r <= numer;
            den_r  <= denom;
            cnt_r  <= STEPS;
         end
      end
      else
      begin
         rem_r  <= fits ? (rem_sh - {1'b0, den_r}) : rem_sh;
         quot_r <= {quot_r[NUM_W-2:0], fits};
         cnt_r  <= cnt_r - 1'b1;
         done_r <= (cnt_r == CNT_W'(1));
      end
   end

   assign busy = (cnt_r != '0);
   assign done = done_r;
   assign quot = quot_r;

endmodule : tte_divider

// ===== testbench/gauge_cmd_properties.sv
// Port checks for the gauge command register bank
`timescale 1ns/1ps
module gauge_cmd_properties
   import gauge_cmd_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [6:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [15:0] nominal_available_capacity,
   input wire logic [15:0] last_measured_discharge,
   input wire logic        capacity_inaccurate_flag,
   input wire logic        ship_mode,
   input wire logic        full_reinit,
   input wire logic        partial_reinit
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic key_w;  // Key byte written to the trigger this cycle
   assign key_w = reg_wr && reg_addr == ADDR_TRIGGER && reg_wdata == TRIGGER_KEY;
   sequence pulse_s(s); s ##1 !s; endsequence
   full_pulse_a: assert property ($rose(full_reinit) |-> pulse_s(full_reinit))
      else $error("full reinit longer than one cycle");
   full_cause_a: assert property (full_reinit |-> $past(key_w, 2))
      else $error("full reinit without key");
   part_cause_a: assert property (partial_reinit |-> $past(key_w, 2) && !full_reinit)
      else $error("partial reinit wrong cause");
   ship_cause_a: assert property ($rose(ship_mode) |-> $past(key_w, 2))
      else $error("ship entered without key");
   no_key_a: assert property (reg_wr && reg_addr == ADDR_TRIGGER
      && reg_wdata != TRIGGER_KEY |-> ##2 !full_reinit && !partial_reinit)
      else $error("non-key acted");
   full_vals_a: assert property (full_reinit
      |-> nominal_available_capacity == AVAIL_INIT && capacity_inaccurate_flag)
      else $error("full reset values wrong");
   part_keep_a: assert property (partial_reinit
      |-> $stable(nominal_available_capacity) && $stable(last_measured_discharge))
      else $error("partial lost capacity");
   unmapped_rd_a: assert property (reg_rd && reg_addr == 7'h20 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : gauge_cmd_properties
bind gauge_command_register_bank gauge_cmd_properties chk_u (.clk, .sys_rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nominal_available_capacity,
   .last_measured_discharge, .capacity_inaccurate_flag, .ship_mode, .full_reinit,
   .partial_reinit);

// ===== testbench/gp_pin_far_end.sv
// Open-drain pin far end: pull-up plus an external sink
`timescale 1ns/1ps
module gp_pin_far_end
(
   input  wire logic gp_pin_oe,
   input  wire logic gp_pin_o,
   input  wire logic ext_low,
   output logic      pin_level
);
   // Line is high unless either party sinks it
   assign pin_level = !((gp_pin_oe && !gp_pin_o) || ext_low);
endmodule : gp_pin_far_end

// ===== testbench/gauge_command_register_bank_tb_top.sv
// Register-level testbench for the gauge command register bank
`timescale 1ns/1ps
module gauge_command_register_bank_tb_top import gauge_cmd_pkg::*;;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic full_charge = 1'b0, ext_low = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, pack_configuration = 8'h00;
   logic [15:0] at_rate_capacity = 16'h0100, temp_meas = 16'h0456, volt_meas = 16'h2000;
   logic [15:0] init_learned_cap = 16'h0abc, nominal_available_capacity;
   logic [15:0] last_measured_discharge;
   logic gp_pin_i, gp_pin_o, gp_pin_oe, capacity_inaccurate_flag;
   logic ship_mode, full_reinit, partial_reinit;
   int fail_count = 0, num_checks = 0;
   gauge_command_register_bank #(.REFRESH_CYCLES(16)) dut_u (.clk, .sys_rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .at_rate_capacity, .temp_meas, .volt_meas,
      .full_charge, .pack_configuration, .init_learned_cap, .gp_pin_i, .gp_pin_o, .gp_pin_oe,
      .nominal_available_capacity, .last_measured_discharge, .capacity_inaccurate_flag,
      .ship_mode, .full_reinit, .partial_reinit);
   gp_pin_far_end far_u (.gp_pin_oe, .gp_pin_o, .ext_low, .pin_level(gp_pin_i));
   initial forever #12.5 clk = ~clk;
   task chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, e});
   endtask : rd
   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   // Mode write then key write
   task cmd(input logic [7:0] m);
      wr(ADDR_CMD_PIN, m);
      wr(ADDR_TRIGGER, TRIGGER_KEY);
      settle;
   endtask : cmd
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_of_test;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_CMD_PIN, 8'h44);
      wr(ADDR_RATE_LO, 8'h3c);
      wr(ADDR_RATE_HI, 8'h00);
      wr(ADDR_CMD_PIN, 8'hfc);
      chk(nominal_available_capacity, AVAIL_INIT);
      wr(ADDR_TRIGGER, TRIGGER_KEY);
      settle;
      chk(nominal_available_capacity, 16'h003c);
      chk(last_measured_discharge, 16'h0000);
      rd(ADDR_TRIGGER, 8'h00);
      rd(ADDR_CMD_PIN, 8'hc4);
      @(posedge clk) full_charge <= 1'b1;
      @(posedge clk) full_charge <= 1'b0;
      rd(ADDR_CMD_PIN, 8'hc0);
      $display("load test done");
      cmd(8'hd0);
      chk(last_measured_discharge, 16'h003c);
      cmd(8'hc8);
      chk(nominal_available_capacity, 16'h003c);
      wr(ADDR_CMD_PIN, 8'hc2);
      wr(ADDR_TRIGGER, 8'h55);
      settle;
      chk(nominal_available_capacity, 16'h003c);
      rd(ADDR_CMD_PIN, 8'hc2);
      wr(ADDR_TRIGGER, TRIGGER_KEY);
      settle;
      chk(last_measured_discharge, init_learned_cap);
      cmd(8'hc1);
      chk({15'h0000, ship_mode}, 16'h0001);
      $display("command test done");
      wr(ADDR_CMD_PIN, 8'h00);
      settle;
      chk({15'h0000, gp_pin_oe}, 16'h0001);
      chk({15'h0000, ship_mode}, 16'h0000);
      wr(ADDR_CMD_PIN, 8'h80);
      ext_low <= 1'b1;
      repeat (4) @(posedge clk);
      chk({15'h0000, gp_pin_oe}, 16'h0000);
      rd(ADDR_CMD_PIN, 8'h80);
      @(posedge clk) ext_low <= 1'b0;
      repeat (3) @(posedge clk);
      rd(ADDR_CMD_PIN, 8'hc0);
      $display("pin test done");
      wr(ADDR_RATE_LO, 8'h3c);
      wr(ADDR_TTE_HI, 8'hff);
      wr(ADDR_TEMP_LO, 8'hff);
      wr(ADDR_VOLT_HI, 8'hff);
      repeat (150) @(posedge clk);
      rd(ADDR_TTE_LO, 8'h00);
      rd(ADDR_TTE_HI, 8'h01);
      rd(ADDR_TEMP_LO, 8'h56);
      rd(ADDR_TEMP_HI, 8'h04);
      rd(ADDR_VOLT_LO, 8'h88);
      rd(ADDR_VOLT_HI, 8'h13);
      rd(7'h20, 8'h00);
      $display("result test done");
      end_of_test;
   end
endmodule : gauge_command_register_bank_tb_top
